/* rtl/irq_ctrl_consts.svh */
// Purpose: offsets, reset values, field positions and vectors of the interrupt controller
// Assumes: included by the package and the controller; the arbiter uses the numbers with no include of its own
// Notes:   definitions only
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

`define IRQ_NUM_SRC        11
`define IRQ_IDX_W          4

// special-function addresses
`define IRQ_ENA_PRI_ADDR   8'hA8
`define IRQ_ENA_PRIO2_ADDR 8'hA9
`define IRQ_PRIO_PRI_ADDR  8'hB8

// power-on values
`define IRQ_ENA_PRI_RST    8'h00
`define IRQ_ENA_PRIO2_RST  8'hA0
`define IRQ_PRIO_PRI_RST   8'h00

// primary enable / priority fields
`define IRQ_GLOBAL_BIT     7
`define IRQ_CONV_BIT       6
`define IRQ_TMR2_BIT       5
`define IRQ_UART_BIT       4
`define IRQ_TMR1_BIT       3
`define IRQ_EXT1_BIT       2
`define IRQ_TMR0_BIT       1
`define IRQ_EXT0_BIT       0
`define IRQ_PRIO_RSVD_BIT  7

// secondary enable/priority fields
`define IRQ_IVL_PRIO_BIT   6
`define IRQ_PSM_PRIO_BIT   5
`define IRQ_SER_PRIO_BIT   4
`define IRQ_IVL_ENA_BIT    2
`define IRQ_PSM_ENA_BIT    1
`define IRQ_SER_ENA_BIT    0

// vector addresses
`define IRQ_VEC_EXT0       16'h0003
`define IRQ_VEC_TMR0       16'h000B
`define IRQ_VEC_EXT1       16'h0013
`define IRQ_VEC_TMR1       16'h001B
`define IRQ_VEC_UART       16'h0023
`define IRQ_VEC_TMR2       16'h002B
`define IRQ_VEC_CONV       16'h0033
`define IRQ_VEC_SER        16'h003B
`define IRQ_VEC_PSM        16'h0043
`define IRQ_VEC_IVL        16'h0053
`define IRQ_VEC_WDT        16'h005B
`define IRQ_VEC_LOW        16'h0003
`define IRQ_VEC_HIGH       16'h005B

`endif

/* rtl/irq_ctrl_pkg.sv */
// Purpose: shared types of the interrupt controller
// Assumes: constants come from irq_ctrl_consts.svh
// Notes:   source index equals position in the polling order
`include "irq_ctrl_consts.svh"

package irq_ctrl_pkg;

    typedef logic [`IRQ_IDX_W-1:0]   src_idx_t;
    typedef logic [`IRQ_NUM_SRC-1:0] src_vec_t;

    typedef enum logic [`IRQ_IDX_W-1:0] {
        SRC_PSM, SRC_WDT, SRC_EXT0, SRC_CONV, SRC_TMR0, SRC_EXT1,
        SRC_TMR1, SRC_SER, SRC_UART, SRC_TMR2, SRC_IVL
    } irq_src_e;

endpackage : irq_ctrl_pkg

/* rtl/irq_arb_if.sv */
// Purpose: carrier between the controller and its level/poll arbiter
// Assumes: one clock domain, purely combinational exchange
// Notes:   none
`timescale 1ns/1ps

interface irq_arb_if import irq_ctrl_pkg::*; ();
    src_vec_t req;
    src_vec_t hi;
    logic     allow_hi;
    logic     allow_lo;
    logic     win_valid;
    logic     win_hi;
    logic     hi_any;
    src_idx_t win_idx;

    modport ctl (output req, hi, allow_hi, allow_lo,
                 input  win_valid, win_hi, hi_any, win_idx);
    modport arb (input  req, hi, allow_hi, allow_lo,
                 output win_valid, win_hi, hi_any, win_idx);
endinterface : irq_arb_if

/* rtl/irq_arbiter.sv */
// Purpose: picks the winning request by level, then by fixed polling order
// Assumes: req already gated by enables; index 0 polls first
// Notes:   purely combinational
`timescale 1ns/1ps

module irq_arbiter import irq_ctrl_pkg::*; (
    irq_arb_if.arb bus
);

    src_vec_t hi_req;
    src_vec_t lo_req;
    logic     hi_found;
    logic     lo_found;
    src_idx_t hi_idx;
    src_idx_t lo_idx;

    assign hi_req = bus.req & bus.hi & {`IRQ_NUM_SRC{bus.allow_hi}};
    assign lo_req = bus.req & ~bus.hi & {`IRQ_NUM_SRC{bus.allow_lo}};

    // walk downward so the lowest index, first in the poll, ends up chosen
    always_comb begin
        hi_found = 1'b0;
        lo_found = 1'b0;
        hi_idx   = '0;
        lo_idx   = '0;
        for (int i = `IRQ_NUM_SRC - 1; i >= 0; i--) begin
            if (hi_req[i]) begin
                hi_found = 1'b1;
                hi_idx   = src_idx_t'(i);
            end
            if (lo_req[i]) begin
                lo_found = 1'b1;
                lo_idx   = src_idx_t'(i);
            end
        end
    end

    assign bus.hi_any    = hi_found;
    assign bus.win_valid = hi_found | lo_found;
    assign bus.win_hi    = hi_found;
    assign bus.win_idx   = hi_found ? hi_idx : lo_idx;

endmodule : irq_arbiter

/* rtl/two_level_irq_ctrl.sv */
// Purpose: two-level interrupt controller, eleven sources, vectors to the core
// Assumes: source flags are levels held by their peripherals until cleared
// Notes:   register reads return data one cycle after sfr_rd_i
`timescale 1ns/1ps
`include "irq_ctrl_consts.svh"

module two_level_irq_ctrl import irq_ctrl_pkg::*; (
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    input  wire logic        sfr_bit_wr_i,
    input  wire logic [2:0]  sfr_bit_sel_i,
    input  wire logic        sfr_bit_val_i,
    input  wire logic        sfr_rd_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic        supply_monitor_irq_flag_i,
    input  wire logic        ext_irq0_flag_i,
    input  wire logic        converter_ready_flags_i,
    input  wire logic        timer0_overflow_flag_i,
    input  wire logic        ext_irq1_flag_i,
    input  wire logic        timer1_overflow_flag_i,
    input  wire logic        serial_link_irq_flags_i,
    input  wire logic        uart_rx_tx_flags_i,
    input  wire logic        timer2_event_flags_i,
    input  wire logic        interval_counter_irq_flag_i,
    input  wire logic        wdt_timeout_i,
    input  wire logic        wdt_irq_mode_i,
    input  wire logic [3:0]  wdt_timeout_sel_i,
    output logic             wdt_reset_o,
    input  wire logic        instr_boundary_i,
    output logic             irq_req_o,
    output logic      [15:0] irq_vector_o,
    output logic             irq_level_hi_o,
    input  wire logic        irq_ack_i,
    input  wire logic        reti_i,
    output logic      [10:0] irq_ack_src_o,
    output logic             in_service_hi_o,
    output logic             in_service_lo_o
);

    logic [7:0] irq_enable_primary_ff;
    logic [7:0] irq_priority_primary_ff;
    logic [7:0] irq_enable_priority_secondary_ff;
    logic       watchdog_irq_flag_ff;
    logic       req_ff;
    logic       req_hi_ff;
    src_idx_t   req_idx_ff;
    logic [15:0] vec_ff;
    logic       ins_hi_ff;
    logic       ins_lo_ff;
    src_vec_t   ack_src_ff;
    logic [7:0] rdata_ff;
    logic       wdt_rst_ff;
    logic [15:0] nxt_vec;
    src_vec_t   flags;
    src_vec_t   ena;
    src_vec_t   prio;
    logic       global_irq_enable;
    logic       accept;
    logic       present;
    logic       ack_src_o_nonzero;

    irq_arb_if arb_bus ();

    irq_arbiter u_arb (
        .bus (arb_bus.arb)
    );

    // byte writes to the enable and priority registers, bit writes to the primary two only
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            irq_enable_primary_ff            <= `IRQ_ENA_PRI_RST;
            irq_priority_primary_ff          <= `IRQ_PRIO_PRI_RST;
            irq_enable_priority_secondary_ff <= `IRQ_ENA_PRIO2_RST;
        end else if (sfr_wr_i) begin
            if (sfr_addr_i == `IRQ_ENA_PRI_ADDR)
                irq_enable_primary_ff <= sfr_wdata_i;
            if (sfr_addr_i == `IRQ_PRIO_PRI_ADDR)
                irq_priority_primary_ff <= sfr_wdata_i;
            // bit 3 stored as written; software keeps it at 0
            if (sfr_addr_i == `IRQ_ENA_PRIO2_ADDR)
                irq_enable_priority_secondary_ff <= sfr_wdata_i;
        end else if (sfr_bit_wr_i) begin
            // the secondary register has no bit address, so it is left alone
            if (sfr_addr_i == `IRQ_ENA_PRI_ADDR)
                irq_enable_primary_ff[sfr_bit_sel_i] <= sfr_bit_val_i;
            if (sfr_addr_i == `IRQ_PRIO_PRI_ADDR)
                irq_priority_primary_ff[sfr_bit_sel_i] <= sfr_bit_val_i;
        end
    end

    // registered read data, reserved priority bit reads zero
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 8'h00;
        end else if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                `IRQ_ENA_PRI_ADDR:   rdata_ff <= irq_enable_primary_ff;
                `IRQ_ENA_PRIO2_ADDR: rdata_ff <= irq_enable_priority_secondary_ff;
                `IRQ_PRIO_PRI_ADDR:  rdata_ff <= irq_priority_primary_ff & 8'h7F;
                default:             rdata_ff <= 8'h00;
            endcase
        end
    end

    // watchdog: reset or latched interrupt; set wins over the clear on accept
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            watchdog_irq_flag_ff <= 1'b0;
            wdt_rst_ff           <= 1'b0;
        end else begin
            wdt_rst_ff <= wdt_timeout_i & ~wdt_irq_mode_i;
            if (wdt_timeout_i && wdt_irq_mode_i && (wdt_timeout_sel_i != 4'h0))
                watchdog_irq_flag_ff <= 1'b1;
            else if (accept && (req_idx_ff == SRC_WDT))
                watchdog_irq_flag_ff <= 1'b0;
        end
    end

    assign global_irq_enable = irq_enable_primary_ff[`IRQ_GLOBAL_BIT];

    assign flags = {interval_counter_irq_flag_i, timer2_event_flags_i, uart_rx_tx_flags_i,
                    serial_link_irq_flags_i, timer1_overflow_flag_i, ext_irq1_flag_i,
                    timer0_overflow_flag_i, converter_ready_flags_i, ext_irq0_flag_i,
                    watchdog_irq_flag_ff, supply_monitor_irq_flag_i};

    // per-source enables, in poll order; watchdog bypasses the global bit
    assign ena = {irq_enable_priority_secondary_ff[`IRQ_IVL_ENA_BIT] & global_irq_enable,
                  irq_enable_primary_ff[`IRQ_TMR2_BIT] & global_irq_enable,
                  irq_enable_primary_ff[`IRQ_UART_BIT] & global_irq_enable,
                  irq_enable_priority_secondary_ff[`IRQ_SER_ENA_BIT] & global_irq_enable,
                  irq_enable_primary_ff[`IRQ_TMR1_BIT] & global_irq_enable,
                  irq_enable_primary_ff[`IRQ_EXT1_BIT] & global_irq_enable,
                  irq_enable_primary_ff[`IRQ_TMR0_BIT] & global_irq_enable,
                  irq_enable_primary_ff[`IRQ_CONV_BIT] & global_irq_enable,
                  irq_enable_primary_ff[`IRQ_EXT0_BIT] & global_irq_enable,
                  1'b1,
                  irq_enable_priority_secondary_ff[`IRQ_PSM_ENA_BIT] & global_irq_enable};

    assign prio = {irq_enable_priority_secondary_ff[`IRQ_IVL_PRIO_BIT],
                   irq_priority_primary_ff[`IRQ_TMR2_BIT],
                   irq_priority_primary_ff[`IRQ_UART_BIT],
                   irq_enable_priority_secondary_ff[`IRQ_SER_PRIO_BIT],
                   irq_priority_primary_ff[`IRQ_TMR1_BIT],
                   irq_priority_primary_ff[`IRQ_EXT1_BIT],
                   irq_priority_primary_ff[`IRQ_TMR0_BIT],
                   irq_priority_primary_ff[`IRQ_CONV_BIT],
                   irq_priority_primary_ff[`IRQ_EXT0_BIT],
                   1'b1,
                   irq_enable_priority_secondary_ff[`IRQ_PSM_PRIO_BIT]};

    assign arb_bus.req      = flags & ena;
    assign arb_bus.hi       = prio;
    assign arb_bus.allow_hi = ~ins_hi_ff;
    assign arb_bus.allow_lo = ~ins_hi_ff & ~ins_lo_ff;

    always_comb begin
        unique case (irq_src_e'(arb_bus.win_idx))
            SRC_PSM:  nxt_vec = `IRQ_VEC_PSM;
            SRC_WDT:  nxt_vec = `IRQ_VEC_WDT;
            SRC_EXT0: nxt_vec = `IRQ_VEC_EXT0;
            SRC_CONV: nxt_vec = `IRQ_VEC_CONV;
            SRC_TMR0: nxt_vec = `IRQ_VEC_TMR0;
            SRC_EXT1: nxt_vec = `IRQ_VEC_EXT1;
            SRC_TMR1: nxt_vec = `IRQ_VEC_TMR1;
            SRC_SER:  nxt_vec = `IRQ_VEC_SER;
            SRC_UART: nxt_vec = `IRQ_VEC_UART;
            SRC_TMR2: nxt_vec = `IRQ_VEC_TMR2;
            SRC_IVL:  nxt_vec = `IRQ_VEC_IVL;
            // index field is four bits wide, so unused codes exist
            default:  nxt_vec = `IRQ_VEC_LOW;
        endcase
    end

    assign present = instr_boundary_i & ~req_ff & arb_bus.win_valid;
    assign accept  = req_ff & irq_ack_i;

    // request stays latched until the core takes it; no re-arbitration meanwhile
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            req_ff     <= 1'b0;
            req_hi_ff  <= 1'b0;
            req_idx_ff <= '0;
            vec_ff     <= 16'h0000;
        end else if (present) begin
            req_ff     <= 1'b1;
            req_hi_ff  <= arb_bus.win_hi;
            req_idx_ff <= arb_bus.win_idx;
            vec_ff     <= nxt_vec;
        end else if (accept) begin
            req_ff <= 1'b0;
        end
    end

    // levels in service; return releases the higher active level first
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ins_hi_ff <= 1'b0;
            ins_lo_ff <= 1'b0;
        end else begin
            if (reti_i) begin
                if (ins_hi_ff)
                    ins_hi_ff <= 1'b0;
                else
                    ins_lo_ff <= 1'b0;
            end
            if (accept) begin
                if (req_hi_ff)
                    ins_hi_ff <= 1'b1;
                else
                    ins_lo_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i)
            ack_src_ff <= '0;
        else
            ack_src_ff <= accept ? (src_vec_t'(1) << req_idx_ff) : '0;
    end

    assign sfr_rdata_o     = rdata_ff;
    assign wdt_reset_o     = wdt_rst_ff;
    assign irq_req_o       = req_ff;
    assign irq_vector_o    = vec_ff;
    assign irq_level_hi_o  = req_hi_ff;
    assign irq_ack_src_o   = ack_src_ff;
    assign in_service_hi_o = ins_hi_ff;
    assign in_service_lo_o = ins_lo_ff;

    a_global_masks: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(req_ff) && !$past(global_irq_enable) |-> req_idx_ff == SRC_WDT)
        else $error("masked source presented while global enable was off");

    a_vector_range: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        req_ff |-> vec_ff >= `IRQ_VEC_LOW && vec_ff <= `IRQ_VEC_HIGH && vec_ff[2:0] == 3'h3)
        else $error("vector outside the table");

    a_boundary_only: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(req_ff) |-> $past(instr_boundary_i))
        else $error("request presented off an instruction boundary");

    a_same_level: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(req_ff) |-> !$past(ins_hi_ff) && (!$past(ins_lo_ff) || req_hi_ff))
        else $error("request of the running level preempted");

    a_high_first: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        $rose(req_ff) && $past(arb_bus.hi_any) |-> req_hi_ff)
        else $error("low level chosen over pending high level");

    a_accept_level: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        accept && !reti_i |=> !req_ff && (req_hi_ff ? ins_hi_ff : ins_lo_ff)
            && ack_src_o_nonzero)
        else $error("accepted level not recorded");

    assign ack_src_o_nonzero = |ack_src_ff;

    a_reti_release: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        reti_i && !accept && ins_hi_ff |=> !ins_hi_ff ##1 $stable(ins_lo_ff) || reti_i)
        else $error("return did not release the high level");

    a_wdt_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wdt_timeout_i && wdt_timeout_sel_i == 4'h0 && !watchdog_irq_flag_ff |=>
            !watchdog_irq_flag_ff)
        else $error("watchdog interrupt with zero timeout");

    a_wdt_reset: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        wdt_timeout_i |=> wdt_reset_o == !$past(wdt_irq_mode_i))
        else $error("watchdog reset does not follow the mode");

    a_secondary_rst: assert property (@(posedge ref_clk_i)
        $fell(sys_rst_i) |-> irq_enable_priority_secondary_ff == `IRQ_ENA_PRIO2_RST
            && irq_enable_primary_ff == `IRQ_ENA_PRI_RST)
        else $error("registers not at power-on values");

    a_no_bit_write2: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i == `IRQ_ENA_PRIO2_ADDR |=>
            $stable(irq_enable_priority_secondary_ff))
        else $error("bit write changed the secondary register");

endmodule : two_level_irq_ctrl

/* tb/core_model.sv */
// Purpose: core side of the vector link: boundaries, acknowledge, vector capture
// Assumes: driven on falling edge, design samples on rising edge
// Notes:   slow_i delays the acknowledge by four cycles
`timescale 1ns/1ps

module core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [15:0] vec_i,
    input  wire logic        hi_i,
    input  wire logic        slow_i,
    output logic             boundary_o,
    output logic             ack_o,
    output logic      [15:0] last_vec_o,
    output logic             last_hi_o,
    output logic      [7:0]  ack_cnt_o
);
    logic [1:0] phase_ff;
    int         wait_cnt;

    initial begin
        boundary_o = 1'b0;
        ack_o      = 1'b0;
    end

    // boundary two cycles in three, so requests wait on it
    always @(negedge clk_i) begin
        if (rst_i) begin
            boundary_o <= 1'b0;
            ack_o      <= 1'b0;
            phase_ff   <= 2'h0;
            wait_cnt   <= 0;
        end else begin
            phase_ff   <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
            boundary_o <= (phase_ff != 2'h0);
            if (ack_o) begin
                ack_o <= 1'b0;
            end else if (req_i) begin
                // acknowledge only while the request stands
                if (wait_cnt >= (slow_i ? 4 : 0)) begin
                    ack_o    <= 1'b1;
                    wait_cnt <= 0;
                end else begin
                    wait_cnt <= wait_cnt + 1;
                end
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_cnt_o <= 8'h00;
        end else if (ack_o && req_i) begin
            last_vec_o <= vec_i;
            last_hi_o  <= hi_i;
            ack_cnt_o  <= ack_cnt_o + 8'h01;
        end
    end
endmodule : core_model

/* tb/two_level_interrupt_controller_bench.sv */
// Purpose: self-checking bench of the two-level interrupt controller
// Assumes: inputs change on the falling edge
// Notes:   sources indexed in polling order
`timescale 1ns/1ps
`include "irq_ctrl_consts.svh"

module two_level_interrupt_controller_bench import irq_ctrl_pkg::*; ();
    logic ref_clk = 0, sys_rst = 1, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 0, sfr_rd = 0;
    logic wdt_timeout = 0, wdt_mode = 0, reti = 0, slow = 0, seen;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, rdata, ack_cnt, d, v, ie_v, ip_v, ie2_v;
    logic [2:0] bit_sel = 0;
    logic [3:0] wdt_sel = 0;
    logic [15:0] vec, last_vec;
    src_vec_t flags = 0;
    src_vec_t ack_src;
    logic boundary, ack, req, lvl_hi, in_hi, in_lo, wdt_rst, last_hi;
    int miscompares = 0, check_count = 0, q[10] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10}, i, j, t;

    always #50 ref_clk = ~ref_clk;

    two_level_irq_ctrl DUT (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .sfr_addr_i(sfr_addr),
        .sfr_wr_i(sfr_wr), .sfr_wdata_i(sfr_wdata), .sfr_bit_wr_i(sfr_bit_wr),
        .sfr_bit_sel_i(bit_sel), .sfr_bit_val_i(sfr_bit_val), .sfr_rd_i(sfr_rd),
        .sfr_rdata_o(rdata), .supply_monitor_irq_flag_i(flags[0]), .ext_irq0_flag_i(flags[2]),
        .converter_ready_flags_i(flags[3]), .timer0_overflow_flag_i(flags[4]),
        .ext_irq1_flag_i(flags[5]), .timer1_overflow_flag_i(flags[6]),
        .serial_link_irq_flags_i(flags[7]), .uart_rx_tx_flags_i(flags[8]),
        .timer2_event_flags_i(flags[9]), .interval_counter_irq_flag_i(flags[10]),
        .wdt_timeout_i(wdt_timeout), .wdt_irq_mode_i(wdt_mode), .wdt_timeout_sel_i(wdt_sel),
        .wdt_reset_o(wdt_rst), .instr_boundary_i(boundary), .irq_req_o(req),
        .irq_vector_o(vec), .irq_level_hi_o(lvl_hi), .irq_ack_i(ack), .reti_i(reti),
        .irq_ack_src_o(ack_src), .in_service_hi_o(in_hi), .in_service_lo_o(in_lo));

    core_model CORE (.clk_i(ref_clk), .rst_i(sys_rst), .req_i(req), .vec_i(vec),
        .hi_i(lvl_hi), .slow_i(slow), .boundary_o(boundary), .ack_o(ack),
        .last_vec_o(last_vec), .last_hi_o(last_hi), .ack_cnt_o(ack_cnt));

    function automatic logic [15:0] vec_of(input int s);
        case (s)
            0: return `IRQ_VEC_PSM;   1: return `IRQ_VEC_WDT;  2: return `IRQ_VEC_EXT0;
            3: return `IRQ_VEC_CONV;  4: return `IRQ_VEC_TMR0; 5: return `IRQ_VEC_EXT1;
            6: return `IRQ_VEC_TMR1;  7: return `IRQ_VEC_SER;  8: return `IRQ_VEC_UART;
            9: return `IRQ_VEC_TMR2;  default: return `IRQ_VEC_IVL;
        endcase
    endfunction : vec_of

    function automatic int bitpos(input int s);
        case (s)
            0: return 1; 2: return 0; 3: return 6; 4: return 1; 5: return 2;
            6: return 3; 7: return 0; 8: return 4; 9: return 5; default: return 2;
        endcase
    endfunction : bitpos

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(negedge ref_clk); sfr_addr = a; sfr_wdata = w; sfr_wr = 1;
        @(negedge ref_clk); sfr_wr = 0;
    endtask : wr

    task automatic bw(input logic [7:0] a, input logic [2:0] s, input logic b);
        @(negedge ref_clk); sfr_addr = a; bit_sel = s; sfr_bit_val = b; sfr_bit_wr = 1;
        @(negedge ref_clk); sfr_bit_wr = 0;
    endtask : bw

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk); sfr_addr = a; sfr_rd = 1;
        @(negedge ref_clk); sfr_rd = 0;
        chk(rdata, exp);
    endtask : rdchk

    task automatic add_src(input int s, input logic hi);
        if (s inside {0, 7, 10}) begin
            ie2_v[bitpos(s)] = 1; ie2_v[bitpos(s) + 4] = hi;
        end else begin
            ie_v[bitpos(s)] = 1; ip_v[bitpos(s)] = hi;
        end
    endtask : add_src

    task automatic apply(input logic ea);
        wr(`IRQ_ENA_PRI_ADDR, {ea, ie_v[6:0]});
        wr(`IRQ_PRIO_PRI_ADDR, ip_v);
        wr(`IRQ_ENA_PRIO2_ADDR, ie2_v & 8'hF7);
        ie_v = 0; ip_v = 0; ie2_v = 0;
    endtask : apply

    // a cut-short wait counts as a mismatch and ends the run
    task automatic serve(input int s, input logic hi);
        logic [7:0] c0;
        int n;
        c0 = ack_cnt; n = 0;
        while (ack_cnt === c0 && n < 80) begin @(negedge ref_clk); n++; end
        if (ack_cnt === c0) begin miscompares++; summarize(); end
        // accepted-source pulse stands only in this cycle
        chk(ack_src, src_vec_t'(1) << s);
        chk(last_vec, vec_of(s));
        chk(last_hi, hi);
        chk(hi ? in_hi : in_lo, 1);
        flags[s] = 0;
    endtask : serve

    task automatic done();
        @(negedge ref_clk); reti = 1;
        @(negedge ref_clk); reti = 0;
    endtask : done

    task automatic none(input int n);
        logic [7:0] c0;
        c0 = ack_cnt;
        repeat (n) @(negedge ref_clk);
        chk(ack_cnt, c0);
    endtask : none

    task automatic wdt_pulse();
        @(negedge ref_clk); wdt_timeout = 1;
        @(negedge ref_clk); wdt_timeout = 0;
    endtask : wdt_pulse

    initial begin
        void'($urandom(32'hD1A3));
        ie_v = 0; ip_v = 0; ie2_v = 0;
        repeat (10) @(negedge ref_clk);
        sys_rst = 0;
        rdchk(`IRQ_ENA_PRI_ADDR, `IRQ_ENA_PRI_RST);
        rdchk(`IRQ_ENA_PRIO2_ADDR, `IRQ_ENA_PRIO2_RST);
        rdchk(`IRQ_PRIO_PRI_ADDR, `IRQ_PRIO_PRI_RST);
        repeat (4) begin
            v = $urandom;
            wr(`IRQ_ENA_PRI_ADDR, v); rdchk(`IRQ_ENA_PRI_ADDR, v);
            wr(`IRQ_PRIO_PRI_ADDR, v); rdchk(`IRQ_PRIO_PRI_ADDR, v & 8'h7F);
            wr(`IRQ_ENA_PRIO2_ADDR, v & 8'hF7); rdchk(`IRQ_ENA_PRIO2_ADDR, v & 8'hF7);
            wr(8'hC0, v); rdchk(8'hC0, 8'h00);
        end
        wr(`IRQ_PRIO_PRI_ADDR, 0); bw(`IRQ_PRIO_PRI_ADDR, 6, 1);
        rdchk(`IRQ_PRIO_PRI_ADDR, 8'h40);
        wr(`IRQ_ENA_PRI_ADDR, 0); bw(`IRQ_ENA_PRI_ADDR, 3, 1);
        rdchk(`IRQ_ENA_PRI_ADDR, 8'h08);
        wr(`IRQ_ENA_PRIO2_ADDR, 0); bw(`IRQ_ENA_PRIO2_ADDR, 2, 1);
        rdchk(`IRQ_ENA_PRIO2_ADDR, 8'h00);
        for (int k = 0; k < 10; k++) begin
            j = $urandom % 10; t = q[k]; q[k] = q[j]; q[j] = t;
        end
        // one source alone, each except the watchdog, at a random level and core speed
        foreach (q[k]) begin
            v[0] = $urandom; slow = $urandom;
            add_src(q[k], v[0]); apply(1);
            flags[q[k]] = 1;
            serve(q[k], v[0]);
            done();
        end
        // all but the watchdog pending while globally blocked, then drained in poll order
        foreach (q[k]) add_src(q[k], 0);
        apply(0);
        flags = 11'h7FD;
        none(40);
        bw(`IRQ_ENA_PRI_ADDR, 7, 1);
        for (int k = 0; k < 11; k++) begin
            if (k != 1) begin serve(k, 0); done(); end
        end
        repeat (3) begin
            i = q[$urandom % 10]; j = q[$urandom % 10];
            if (i == j) j = (i == 10) ? 0 : 10;
            add_src(i, 0); add_src(j, 1); apply(1);
            flags[i] = 1; flags[j] = 1;
            serve(j, 1);
            done(); serve(i, 0); done();
        end
        add_src(2, 0); add_src(4, 0); add_src(9, 1); apply(1);
        flags[2] = 1; serve(2, 0);
        flags[4] = 1; none(30);
        flags[9] = 1; serve(9, 1);
        done(); none(20);
        done(); serve(4, 0);
        done();
        apply(0);
        wdt_mode = 1; wdt_sel = 0; wdt_pulse();
        none(30);
        wdt_sel = 1 + ($urandom % 15); wdt_pulse();
        serve(1, 1);
        done();
        wdt_mode = 0; wdt_pulse();
        seen = (wdt_rst === 1'b1);
        repeat (4) begin @(negedge ref_clk); if (wdt_rst === 1'b1) seen = 1; end
        chk(seen, 1);
        none(20);
        summarize();
    end
endmodule : two_level_interrupt_controller_bench
